/* File: common/pc_defines.svh */
// Purpose: named constants of the program counter and core context block
// Assumes: register indices are word indices; byte address is index times four
// Notes:   included by the package and by the design modules
`ifndef PC_DEFINES_SVH
`define PC_DEFINES_SVH

// ============================================================================
// widths, stack depth and bit positions
`define PC_W          15
`define LATCH_W       7
`define LOW_W         8
`define SP_W          5
`define STACK_DEPTH   16
`define IDX_W         12
`define FLAGS_W       3
`define BSR_W         5
`define CALL_LOW_W    11
`define CALL_LATCH_LSB 3
`define SLOT_MSB      3

// ============================================================================
// register indices
`define IDX_PCL       12'hF82
`define IDX_LATCH     12'hF8A
`define IDX_SH_FLAGS  12'hFE4
`define IDX_SH_W      12'hFE5
`define IDX_SH_BSR    12'hFE6
`define IDX_SH_LATCH  12'hFE7
`define IDX_SH_F0L    12'hFE8
`define IDX_SH_F0H    12'hFE9
`define IDX_SH_F1L    12'hFEA
`define IDX_SH_F1H    12'hFEB
`define IDX_SP        12'hFED
`define IDX_RETURN_STACK_TOP_LOW      12'hFEE
`define IDX_RETURN_STACK_TOP_HIGH      12'hFEF

// ============================================================================
// reset values, last stack pointer before overflow and fixed addresses
`define PC_RESET      15'h0000
`define LATCH_RESET   7'h00
`define SP_RESET      5'h1F
`define SP_LAST       5'h0F
`define INT_VECTOR    15'h0004

// ============================================================================
// bus field positions
`define ADDR_IDX_LSB  2
`define ADDR_IDX_MSB  13
`define ADDR_TOP_LSB  14

`endif

/* File: common/pc_pkg.sv */
// Purpose: types shared by the program counter block and its return stack
// Assumes: pc_defines.svh supplies every width but the 32-bit hrdata and the 3-bit op code
// Notes:   core operation codes are driven by the instruction decoder
`include "pc_defines.svh"

package pc_pkg;

   // ============================================================================
   // core operation presented once per instruction cycle
   typedef enum logic [2:0] {
      OP_NONE   = 3'b000,
      OP_STEP   = 3'b001,
      OP_PCL_WR = 3'b010,
      OP_CALL   = 3'b011,
      OP_INDIRECT_CALL_INSTR  = 3'b100,
      OP_INT    = 3'b101,
      OP_RET    = 3'b110,
      OP_RETFIE = 3'b111
   } core_op_t;

   // ============================================================================
   // state of the main module
   typedef struct packed {
      logic [`PC_W-1:0]    pc;
      logic [`LATCH_W-1:0] latch;
      logic                bus_wr;
      logic [`IDX_W-1:0]   bus_idx;
      logic [31:0]         hrdata;
      logic                restore;
      logic [`FLAGS_W-1:0] sh_flags;
      logic [`LOW_W-1:0]   sh_w;
      logic [`BSR_W-1:0]   sh_bsr;
      logic [`LATCH_W-1:0] sh_latch;
      logic [`LOW_W-1:0]   sh_f0l;
      logic [`LOW_W-1:0]   sh_f0h;
      logic [`LOW_W-1:0]   sh_f1l;
      logic [`LOW_W-1:0]   sh_f1h;
   } ctx_state_t;

   // ============================================================================
   // state of the return stack
   typedef struct packed {
      logic [`SP_W-1:0] ptr;
      logic             ovf;
      logic             unf;
   } stack_state_t;

endpackage : pc_pkg

/* File: common/stack_if.sv */
// Purpose: link between the program counter block and its return stack
// Assumes: one push, pop or software access per cycle
// Notes:   tos is combinational from the stack array
`timescale 1ns/1ps
`include "pc_defines.svh"

interface stack_if;
   logic                push;
   logic                pop;
   logic [`PC_W-1:0]    push_val;
   logic                ptr_wr;
   logic [`SP_W-1:0]    ptr_wdata;
   logic                return_stack_top_low_wr;
   logic                return_stack_top_high_wr;
   logic [`LOW_W-1:0]   tos_wdata;
   logic [`PC_W-1:0]    tos;
   logic [`SP_W-1:0]    ptr;
   logic                ovf;
   logic                unf;

   modport owner (output push, pop, push_val, ptr_wr, ptr_wdata, return_stack_top_low_wr, return_stack_top_high_wr,
                  tos_wdata, input tos, ptr, ovf, unf);
   modport stack (input push, pop, push_val, ptr_wr, ptr_wdata, return_stack_top_low_wr, return_stack_top_high_wr,
                  tos_wdata, output tos, ptr, ovf, unf);
endinterface : stack_if

/* File: rtl/return_stack.sv */
// Purpose: sixteen-level return stack with a five-bit stack pointer
// Assumes: push and pop never arrive together
// Notes:   circular; overflow and underflow are one-cycle pulses
`timescale 1ns/1ps
`include "pc_defines.svh"

module return_stack
   import pc_pkg::*;
#(
   parameter int DEPTH = `STACK_DEPTH
) (
   input  wire logic clk,
   input  wire logic rst_b,
   stack_if.stack    stk
);

   stack_state_t     s_q;
   stack_state_t     s_d;
   logic [`PC_W-1:0] mem [DEPTH];
   logic [`SLOT_MSB:0] wr_slot;

   // ============================================================================
   // pointer and flags
   always_comb begin
      s_d     = s_q;
      s_d.ovf = 1'b0;
      s_d.unf = 1'b0;
      wr_slot = s_q.ptr[`SLOT_MSB:0];
      if (stk.push) begin
         s_d.ptr = s_q.ptr + 5'h01;
         wr_slot = s_d.ptr[`SLOT_MSB:0];
         s_d.ovf = (s_q.ptr == `SP_LAST);
      end else if (stk.pop) begin
         s_d.ptr = s_q.ptr - 5'h01;
         s_d.unf = (s_q.ptr == `SP_RESET);
      end else if (stk.ptr_wr) begin
         s_d.ptr = stk.ptr_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_q.ptr <= `SP_RESET;
         s_q.ovf <= 1'b0;
         s_q.unf <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ============================================================================
   // storage, not reset
   always_ff @(posedge clk) begin
      if (stk.push) begin
         mem[wr_slot] <= stk.push_val;
      end else if (stk.return_stack_top_low_wr) begin
         mem[wr_slot][`LOW_W-1:0] <= stk.tos_wdata;
      end else if (stk.return_stack_top_high_wr) begin
         mem[wr_slot][`PC_W-1:`LOW_W] <= stk.tos_wdata[`LATCH_W-1:0];
      end
   end

   assign stk.tos = mem[s_q.ptr[`SLOT_MSB:0]];
   assign stk.ptr = s_q.ptr;
   assign stk.ovf = s_q.ovf;
   assign stk.unf = s_q.unf;

endmodule : return_stack

/* File: rtl/pc_core_ctx.sv */
// Purpose: program counter loading, return stack access and interrupt shadows
// Assumes: decoder presents one core_op per cycle; AHB-Lite single word transfers
// Notes:   zero-wait bus slave; a core op wins over a bus write to the pc low byte
//
// Contract
// - Program counter is fifteen bits wide.
// - Low pc byte comes from the readable, writable low byte register.
// - Upper pc bits not directly accessible; they come from the upper latch.
// - Every reset clears the whole program counter to zero.
// - Writing the low byte loads upper bits from the latch at once.
// - Computed jumps: add result written to the low byte register.
// - Direct call: operand gives low byte and bits 2..0; latch gives 6..3.
// - Indirect call: W gives low byte; latch gives the upper bits.
// - Top of stack readable as low and seven-bit high registers, not reset.
// - Calls and interrupt entry push the program counter onto the stack.
// - Stack pointer is five bits to detect overflow and underflow.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`include "pc_defines.svh"

module pc_core_ctx
   import pc_pkg::*;
#(
   parameter logic [`PC_W-1:0] INT_VEC = `INT_VECTOR
) (
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   // ahb-lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   // core side
   input  wire core_op_t             core_op,
   input  wire logic [`PC_W-1:0]     core_operand,
   input  wire logic [`FLAGS_W-1:0]  ctx_flags,
   input  wire logic [`LOW_W-1:0]    ctx_w,
   input  wire logic [`BSR_W-1:0]    ctx_bsr,
   input  wire logic [`LOW_W-1:0]    ctx_fsr0l,
   input  wire logic [`LOW_W-1:0]    ctx_fsr0h,
   input  wire logic [`LOW_W-1:0]    ctx_fsr1l,
   input  wire logic [`LOW_W-1:0]    ctx_fsr1h,
   output logic      [`PC_W-1:0]     pc_addr,
   output logic      [`LATCH_W-1:0]  pc_upper_latch,
   output logic                      restore_valid,
   output logic      [`FLAGS_W-1:0]  restore_flags,
   output logic      [`LOW_W-1:0]    restore_w,
   output logic      [`BSR_W-1:0]    restore_bsr,
   output logic      [`LOW_W-1:0]    restore_fsr0l,
   output logic      [`LOW_W-1:0]    restore_fsr0h,
   output logic      [`LOW_W-1:0]    restore_fsr1l,
   output logic      [`LOW_W-1:0]    restore_fsr1h,
   output logic                      stack_overflow,
   output logic                      stack_underflow
);

   ctx_state_t          s_q;
   ctx_state_t          s_d;
   logic                addr_ok;
   logic                accept;
   logic [`IDX_W-1:0]   a_idx;
   logic [`LOW_W-1:0]   wbyte;

   stack_if stk ();

   return_stack #(
      .DEPTH (`STACK_DEPTH)
   ) u_stack (
      .clk   (clk),
      .rst_b (rst_b),
      .stk   (stk)
   );

   // ============================================================================
   // read mux
   function automatic logic [31:0] read_reg(input ctx_state_t q,
                                            input logic [`IDX_W-1:0] idx,
                                            input logic [`PC_W-1:0] tos,
                                            input logic [`SP_W-1:0] ptr);
      logic [31:0] r;
      r = 32'h0000_0000;
      case (idx)
         `IDX_PCL:      r[`LOW_W-1:0]   = q.pc[`LOW_W-1:0];
         `IDX_LATCH:    r[`LATCH_W-1:0] = q.latch;
         `IDX_SH_FLAGS: r[`FLAGS_W-1:0] = q.sh_flags;
         `IDX_SH_W:     r[`LOW_W-1:0]   = q.sh_w;
         `IDX_SH_BSR:   r[`BSR_W-1:0]   = q.sh_bsr;
         `IDX_SH_LATCH: r[`LATCH_W-1:0] = q.sh_latch;
         `IDX_SH_F0L:   r[`LOW_W-1:0]   = q.sh_f0l;
         `IDX_SH_F0H:   r[`LOW_W-1:0]   = q.sh_f0h;
         `IDX_SH_F1L:   r[`LOW_W-1:0]   = q.sh_f1l;
         `IDX_SH_F1H:   r[`LOW_W-1:0]   = q.sh_f1h;
         `IDX_SP:       r[`SP_W-1:0]    = ptr;
         `IDX_RETURN_STACK_TOP_LOW:     r[`LOW_W-1:0]   = tos[`LOW_W-1:0];
         `IDX_RETURN_STACK_TOP_HIGH:     r[`LATCH_W-1:0] = tos[`PC_W-1:`LOW_W];
         default:       r = 32'h0000_0000;
      endcase
      return r;
   endfunction : read_reg

   // ============================================================================
   // address phase decode
   assign a_idx   = haddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
   assign addr_ok = (haddr[31:`ADDR_TOP_LSB] == 18'h0_0000) && (haddr[1:0] == 2'h0);
   assign accept  = hsel && htrans[1] && hready;
   assign wbyte   = hwdata[`LOW_W-1:0];

   // ============================================================================
   // stack control
   always_comb begin
      stk.push      = (core_op == OP_CALL) || (core_op == OP_INDIRECT_CALL_INSTR) ||
                      (core_op == OP_INT);
      stk.pop       = (core_op == OP_RET) || (core_op == OP_RETFIE);
      stk.push_val  = s_q.pc;
      stk.ptr_wr    = s_q.bus_wr && (s_q.bus_idx == `IDX_SP);
      stk.ptr_wdata = hwdata[`SP_W-1:0];
      stk.return_stack_top_low_wr   = s_q.bus_wr && (s_q.bus_idx == `IDX_RETURN_STACK_TOP_LOW);
      stk.return_stack_top_high_wr   = s_q.bus_wr && (s_q.bus_idx == `IDX_RETURN_STACK_TOP_HIGH);
      stk.tos_wdata = wbyte;
   end

   // ============================================================================
   // next state
   always_comb begin
      s_d         = s_q;
      s_d.restore = 1'b0;

      // bus address phase
      s_d.bus_wr  = 1'b0;
      if (accept) begin
         s_d.bus_idx = a_idx;
         s_d.bus_wr  = hwrite && addr_ok;
         s_d.hrdata  = (!hwrite && addr_ok) ? read_reg(s_q, a_idx, stk.tos, stk.ptr)
                                            : 32'h0000_0000;
      end

      // program counter source
      case (core_op)
         OP_STEP: begin
            s_d.pc = s_q.pc + 15'h0001;
         end
         OP_PCL_WR: begin
            s_d.pc = {s_q.latch, core_operand[`LOW_W-1:0]};
         end
         OP_CALL: begin
            s_d.pc = {s_q.latch[`LATCH_W-1:`CALL_LATCH_LSB],
                      core_operand[`CALL_LOW_W-1:0]};
         end
         OP_INDIRECT_CALL_INSTR: begin
            s_d.pc = {s_q.latch, core_operand[`LOW_W-1:0]};
         end
         OP_INT: begin
            s_d.pc       = INT_VEC;
            s_d.sh_flags = ctx_flags;
            s_d.sh_w     = ctx_w;
            s_d.sh_bsr   = ctx_bsr;
            s_d.sh_latch = s_q.latch;
            s_d.sh_f0l   = ctx_fsr0l;
            s_d.sh_f0h   = ctx_fsr0h;
            s_d.sh_f1l   = ctx_fsr1l;
            s_d.sh_f1h   = ctx_fsr1h;
         end
         OP_RET: begin
            s_d.pc = stk.tos;
         end
         OP_RETFIE: begin
            s_d.pc      = stk.tos;
            s_d.latch   = s_q.sh_latch;
            s_d.restore = 1'b1;
         end
         default: begin
            s_d.pc = s_q.pc;
         end
      endcase

      // bus data phase write
      if (s_q.bus_wr) begin
         case (s_q.bus_idx)
            `IDX_PCL: begin
               if (core_op == OP_NONE) begin
                  s_d.pc = {s_q.latch, wbyte};
               end
            end
            `IDX_LATCH:    s_d.latch    = hwdata[`LATCH_W-1:0];
            `IDX_SH_FLAGS: s_d.sh_flags = hwdata[`FLAGS_W-1:0];
            `IDX_SH_W:     s_d.sh_w     = wbyte;
            `IDX_SH_BSR:   s_d.sh_bsr   = hwdata[`BSR_W-1:0];
            `IDX_SH_LATCH: s_d.sh_latch = hwdata[`LATCH_W-1:0];
            `IDX_SH_F0L:   s_d.sh_f0l   = wbyte;
            `IDX_SH_F0H:   s_d.sh_f0h   = wbyte;
            `IDX_SH_F1L:   s_d.sh_f1l   = wbyte;
            `IDX_SH_F1H:   s_d.sh_f1h   = wbyte;
            default:       s_d.bus_wr   = s_d.bus_wr;
         endcase
      end
   end

   // ============================================================================
   // state register; shadows keep their value through reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_q.pc      <= `PC_RESET;
         s_q.latch   <= `LATCH_RESET;
         s_q.bus_wr  <= 1'b0;
         s_q.bus_idx <= 12'h000;
         s_q.hrdata  <= 32'h0000_0000;
         s_q.restore <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ============================================================================
   // outputs
   assign hrdata          = s_q.hrdata;
   assign hreadyout       = 1'b1;
   assign hresp           = 1'b0;
   assign pc_addr         = s_q.pc;
   assign pc_upper_latch  = s_q.latch;
   assign restore_valid   = s_q.restore;
   assign restore_flags   = s_q.sh_flags;
   assign restore_w       = s_q.sh_w;
   assign restore_bsr     = s_q.sh_bsr;
   assign restore_fsr0l   = s_q.sh_f0l;
   assign restore_fsr0h   = s_q.sh_f0h;
   assign restore_fsr1l   = s_q.sh_f1l;
   assign restore_fsr1h   = s_q.sh_f1h;
   assign stack_overflow  = stk.ovf;
   assign stack_underflow = stk.unf;

endmodule : pc_core_ctx

/* File: testbench/pc_core_ctx_asserts.sv */
// Purpose: port-level assertions for pc_core_ctx
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every pc_core_ctx instance
`timescale 1ns/1ps
`include "pc_defines.svh"

module pc_asserts
   import pc_pkg::*;
#(
   parameter logic [`PC_W-1:0] INT_VEC = `INT_VECTOR
) (
   input wire logic                clk,
   input wire logic                rst_b,
   input wire logic                hreadyout,
   input wire logic                hresp,
   input wire core_op_t            core_op,
   input wire logic [`PC_W-1:0]    core_operand,
   input wire logic [`PC_W-1:0]    pc_addr,
   input wire logic [`LATCH_W-1:0] pc_upper_latch,
   input wire logic                restore_valid
);
   // ==========================================================================
   // helper copies of the previous cycle; pc_qq holds the pc of two cycles back
   logic [`PC_W-1:0]    op_q;
   logic [`PC_W-1:0]    pc_q;
   logic [`PC_W-1:0]    pc_qq;
   logic [`LATCH_W-1:0] lat_q;

   always_ff @(posedge clk) begin
      op_q  <= core_operand;
      pc_q  <= pc_addr;
      pc_qq <= pc_q;
      lat_q <= pc_upper_latch;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence call_s;
      core_op == OP_CALL;
   endsequence
   sequence ret_s;
      core_op == OP_RET;
   endsequence

   // ==========================================================================
   // assertions
   reset_clears_pc_a: assert property (
      $rose(rst_b) |-> pc_addr == 15'h0000 && pc_upper_latch == 7'h00)
      else $error("pc or latch not cleared by reset");
   step_incr_a: assert property (
      core_op == OP_STEP |=> pc_addr == pc_q + 15'h0001)
      else $error("pc step wrong");
   pcl_load_a: assert property (
      core_op == OP_PCL_WR |=> pc_addr == {lat_q, op_q[7:0]})
      else $error("low byte write did not load latch");
   call_load_a: assert property (
      core_op == OP_CALL |=> pc_addr == {lat_q[6:3], op_q[10:0]})
      else $error("direct call target wrong");
   indirect_call_instr_load_a: assert property (
      core_op == OP_INDIRECT_CALL_INSTR |=> pc_addr == {lat_q, op_q[7:0]})
      else $error("indirect call target wrong");
   int_vector_a: assert property (
      core_op == OP_INT |=> pc_addr == INT_VEC)
      else $error("interrupt vector wrong");
   call_return_a: assert property (
      call_s ##1 ret_s |=> pc_addr == pc_qq)
      else $error("return address wrong");
   restore_pulse_a: assert property (
      core_op == OP_RETFIE |=> restore_valid)
      else $error("restore pulse missing");
   restore_cause_a: assert property (
      restore_valid |-> $past(core_op) == OP_RETFIE)
      else $error("restore pulse without return");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus not ready or error response");
endmodule : pc_asserts

bind pc_core_ctx pc_asserts #(.INT_VEC(INT_VEC)) u_chk (.clk, .rst_b, .hreadyout, .hresp,
   .core_op, .core_operand, .pc_addr, .pc_upper_latch, .restore_valid);

/* File: testbench/program_counter_load_tb_top.sv */
// Purpose: self-checking bench for pc_core_ctx
// Assumes: zero-wait AHB-Lite slave, one core op per cycle
// Notes:   expectations are worked out from the register map
`timescale 1ns/1ps
`include "pc_defines.svh"

module program_counter_load_tb_top
   import pc_pkg::*;
;
   logic             clk = 1'b0;
   logic             rst_b, hsel, hwrite, hreadyout, hresp;
   logic             restore_valid, stack_overflow, stack_underflow;
   logic [1:0]       htrans;
   logic [2:0]       hsize, ctx_flags, restore_flags;
   logic [4:0]       ctx_bsr, restore_bsr;
   logic [7:0]       ctx_w, ctx_fsr0l, ctx_fsr0h, ctx_fsr1l, ctx_fsr1h, restore_w;
   logic [7:0]       restore_fsr0l, restore_fsr0h, restore_fsr1l, restore_fsr1h;
   logic [14:0]      core_operand, pc_addr;
   logic [6:0]       pc_upper_latch;
   logic [31:0]      haddr, hwdata, hrdata, rd;
   core_op_t         core_op;
   int               n_errors = 0;
   int               checks = 0;
   int               cyc = 0;
   logic [7:0]       sh [8] = '{8'h05, 8'hC3, 8'h11, 8'h55, 8'hA1, 8'hB2, 8'hC4, 8'hD8};

   pc_core_ctx u_dut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .core_op, .core_operand,
      .ctx_flags, .ctx_w, .ctx_bsr, .ctx_fsr0l, .ctx_fsr0h, .ctx_fsr1l, .ctx_fsr1h,
      .pc_addr, .pc_upper_latch, .restore_valid, .restore_flags, .restore_w, .restore_bsr,
      .restore_fsr0l, .restore_fsr0h, .restore_fsr1l, .restore_fsr1h, .stack_overflow,
      .stack_underflow);

   always #10 clk = ~clk;

   // ==========================================================================
   // shared tasks
   task automatic results;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {18'h0, idx, 2'b00};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 32'h0000_0000);
      chk(rd, exp);
   endtask : rd_chk

   task automatic pc_is(input logic [14:0] exp);
      #1;
      chk({17'h0, pc_addr}, {17'h0, exp});
   endtask : pc_is

   task automatic op(input core_op_t o, input logic [14:0] v, input logic [14:0] exp);
      @(posedge clk);
      core_op      <= o;
      core_operand <= v;
      @(posedge clk);
      core_op <= OP_NONE;
      pc_is(exp);
   endtask : op

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         results();
      end
   end

   // ==========================================================================
   // main sequence
   initial begin
      rst_b <= 1'b0; hsel <= 1'b0; htrans <= 2'b00; hwrite <= 1'b0; hsize <= 3'b010;
      haddr <= 32'h0000_0000; hwdata <= 32'h0000_0000;
      core_op <= OP_NONE; core_operand <= 15'h0000;
      ctx_flags <= sh[0][2:0]; ctx_w <= sh[1]; ctx_bsr <= sh[2][4:0];
      ctx_fsr0l <= sh[4]; ctx_fsr0h <= sh[5]; ctx_fsr1l <= sh[6]; ctx_fsr1h <= sh[7];
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      pc_is(15'h0000);
      rd_chk(`IDX_SP, 32'h0000_001F);
      rd_chk(`IDX_PCL, 32'h0000_0000);
      bus(1'b1, 12'hFEC, 32'hFFFF_FFFF);
      rd_chk(12'hFEC, 32'h0000_0000);
      $display("test reset_map done");
      bus(1'b1, `IDX_LATCH, 32'h0000_0012);
      pc_is(15'h0000);
      bus(1'b1, `IDX_LATCH, 32'h0000_0055);
      bus(1'b1, `IDX_PCL, 32'h0000_003C);
      pc_is(15'h553C);
      rd_chk(`IDX_PCL, 32'h0000_003C);
      $display("test bus_load done");
      op(OP_PCL_WR, 15'h00A7, 15'h55A7);
      op(OP_CALL, 15'h05B3, 15'h55B3);
      op(OP_STEP, 15'h0000, 15'h55B4);
      op(OP_INDIRECT_CALL_INSTR, 15'h0019, 15'h5519);
      rd_chk(`IDX_SP, 32'h0000_0001);
      rd_chk(`IDX_RETURN_STACK_TOP_LOW, 32'h0000_00B4);
      rd_chk(`IDX_RETURN_STACK_TOP_HIGH, 32'h0000_0055);
      op(OP_INT, 15'h0000, 15'h0004);
      ctx_w <= 8'h00;
      for (int i = 0; i < 8; i++) rd_chk(12'(`IDX_SH_FLAGS + i), {24'h0, sh[i]});
      bus(1'b1, `IDX_SH_LATCH, 32'h0000_002A);
      op(OP_RETFIE, 15'h0000, 15'h5519);
      chk({31'h0, restore_valid}, 32'h0000_0001);
      chk({24'h0, restore_w}, 32'h0000_00C3);
      chk({29'h0, restore_flags}, 32'h0000_0005);
      chk({27'h0, restore_bsr}, 32'h0000_0011);
      chk({restore_fsr1h, restore_fsr1l, restore_fsr0h, restore_fsr0l}, 32'hD8C4_B2A1);
      chk({25'h0, pc_upper_latch}, 32'h0000_002A);
      op(OP_RET, 15'h0000, 15'h55B4);
      op(OP_RET, 15'h0000, 15'h55A7);
      // call directly followed by return
      @(posedge clk);
      core_op      <= OP_CALL;
      core_operand <= 15'h0123;
      @(posedge clk);
      core_op <= OP_RET;
      pc_is(15'h2923);
      @(posedge clk);
      core_op <= OP_NONE;
      pc_is(15'h55A7);
      $display("test core_ops done");
      for (int i = 0; i < 17; i++) begin
         op(OP_INDIRECT_CALL_INSTR, 15'(i), {7'h2A, 8'(i)});
         chk({31'h0, stack_overflow}, {31'h0, i == 16});
      end
      bus(1'b1, `IDX_SP, 32'h0000_001F);
      op(OP_RET, 15'h0000, 15'h2A0E);
      chk({31'h0, stack_underflow}, 32'h0000_0001);
      bus(1'b1, `IDX_RETURN_STACK_TOP_LOW, 32'h0000_005A);
      bus(1'b1, `IDX_RETURN_STACK_TOP_HIGH, 32'h0000_0093);
      rd_chk(`IDX_RETURN_STACK_TOP_HIGH, 32'h0000_0013);
      op(OP_RET, 15'h0000, 15'h135A);
      $display("test stack_limits done");
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      pc_is(15'h0000);
      rd_chk(`IDX_SP, 32'h0000_001F);
      rd_chk(`IDX_LATCH, 32'h0000_0000);
      rd_chk(`IDX_SH_LATCH, 32'h0000_002A);
      $display("test mid_reset done");
      results();
   end
endmodule : program_counter_load_tb_top
